// ---- src/aas_pkg.sv ----
`default_nettype none
package aas_pkg;
    localparam int DATA_W = 24;
    localparam int WAIT_W = 5;
    localparam int NUM_ATTR = 4;

    // register byte offsets on the control bus
    localparam logic [7:0] OFS_BUS_TIMING = 8'h00;
    localparam logic [7:0] OFS_ATTR_ZERO = 8'h04;
    localparam logic [7:0] OFS_ATTR_ONE = 8'h08;
    localparam logic [7:0] OFS_ATTR_TWO = 8'h0c;
    localparam logic [7:0] OFS_ATTR_THREE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // reset values
    localparam logic [23:0] BUS_TIMING_RST = 24'h0f_ffff;
    localparam logic [23:0] ATTR_RST = 24'h00_0000;

    // bus_timing_control layout: area k wait count at [5k+4:5k]
    localparam int AREA_WAIT_LSB = 0;
    localparam int BUS_REQUEST_HOLD_BIT = 21;
    localparam int BUS_LOCK_HOLD_BIT = 22;

    // attr_select_reg layout
    localparam int ATTR_POL_BIT = 2;
    localparam int ATTR_SPACE_LSB = 3;
    localparam int ATTR_CNT_LSB = 8;
    localparam int ATTR_CNT_W = 4;
    localparam int ATTR_ADDR_LSB = 12;
    localparam int ATTR_ADDR_W = 12;

    localparam logic [4:0] MAX_WAIT = 5'h1f;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        AAS_SPACE_P = 2'h0,
        AAS_SPACE_X = 2'h1,
        AAS_SPACE_Y = 2'h2
    } aas_space_t;

    typedef enum logic [2:0] {
        AAS_IDLE = 3'h1,
        AAS_BUSY = 3'h2,
        AAS_LENT = 3'h4
    } aas_acc_state_t;
endpackage
`default_nettype wire

// ---- src/aas_attr_match.sv ----
`default_nettype none
module aas_attr_match (
    input wire logic [23:0] attr_reg,
    input wire logic [23:0] addr,
    input wire logic [1:0] space,
    output logic hit
);
    logic [aas_pkg::ATTR_ADDR_W-1:0] bit_ok;
    logic [aas_pkg::ATTR_CNT_W-1:0] cnt;
    logic space_ok;

    assign cnt = attr_reg[aas_pkg::ATTR_CNT_LSB +: aas_pkg::ATTR_CNT_W];

    // compared bits run from address bit 23 downward, cnt of them
    genvar i;
    generate
        for (i = 0; i < aas_pkg::ATTR_ADDR_W; i++) begin : g_bit
            assign bit_ok[i] = (32'(i) >= 32'(cnt)) ||
                (addr[23 - i] == attr_reg[23 - i]);
        end
    endgenerate

    // space code 3 is no space at all and never matches
    assign space_ok = (space != 2'h3) &&
        attr_reg[aas_pkg::ATTR_SPACE_LSB + 32'(space)];

    assign hit = space_ok && (&bit_ok);
endmodule
`default_nettype wire

// ---- src/aas_wait_gen.sv ----
`default_nettype none
module aas_wait_gen (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic busy,
    input wire logic [4:0] wait_cnt,
    input wire logic ack,
    output logic fin,
    output logic [4:0] elapsed
);
    typedef struct packed {
        logic [4:0] cnt;
    } aas_wait_st_t;

    aas_wait_st_t s_r;
    aas_wait_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (start) begin
            s_nxt.cnt = 5'h00;
        end else if (busy && s_r.cnt != aas_pkg::MAX_WAIT) begin
            s_nxt.cnt = s_r.cnt + 5'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // longer of programmed count and external acknowledge wins
    assign fin = busy && (s_r.cnt >= wait_cnt) && ack;
    assign elapsed = s_r.cnt;
endmodule
`default_nettype wire

// ---- src/aas_chip_select.sv ----
// Operation
// - each access waits the longer of programmed count and acknowledge delay.
// - programmed wait count per access ranges from zero to thirty-one.
// - external port has 24-bit data bus and separate 24-bit address bus.
// - three spaces, two data and one program, each 16M words of 24 bits.
// - zero-wait accesses can follow one per clock cycle.
// - attribute pins change with the same timing as the address bus.
// - pin asserts only when upper address bits and space match its register.
// - reset clears all four attribute registers, disabling every pin.
// - among several matching registers the highest index wins.
// - pin negates after access unless next access selects the same pin.
// - four readable and writable 24-bit attribute registers, one per pin.
// - an external master may borrow the bus while internals continue.
`default_nettype none
module aas_chip_select #(
    parameter int AXI_AW = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic acc_valid,
    output logic acc_ready,
    input wire logic [23:0] acc_addr,
    input wire logic [1:0] acc_space,
    input wire logic acc_write,
    input wire logic [23:0] acc_wdata,
    output logic acc_done,
    output logic [23:0] acc_rdata,
    output logic [23:0] ext_addr,
    output logic [23:0] ext_data_out,
    output logic ext_data_oe,
    input wire logic [23:0] ext_data_in,
    output logic ext_rd_n,
    output logic ext_wr_n,
    output logic ext_bus_oe,
    output logic [3:0] attr_select_pin,
    input wire logic transfer_ack_in,
    input wire logic ext_bus_req,
    output logic ext_bus_grant
);
    typedef struct packed {
        logic [23:0] bus_timing_control;
        logic [3:0][23:0] attr_select_reg;
        logic aw_got;
        logic w_got;
        logic [AXI_AW-1:0] wr_addr;
        logic [23:0] wr_data;
        logic [2:0] wr_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [23:0] rdata;
        aas_pkg::aas_acc_state_t state;
        logic pend;
        logic [23:0] pend_addr;
        logic [1:0] pend_space;
        logic pend_write;
        logic [23:0] pend_wdata;
        logic [4:0] cur_wait;
        logic cur_write;
        logic [3:0] sel;
        logic [23:0] ext_addr;
        logic [23:0] ext_dout;
        logic ext_data_oe;
        logic rd_n;
        logic wr_n;
        logic bus_oe;
        logic [3:0] pins;
        logic acc_ready;
        logic acc_done;
        logic [23:0] acc_rdata;
        logic grant;
    } aas_core_st_t;

    aas_core_st_t s_r;
    aas_core_st_t s_nxt;

    logic fin;
    logic [4:0] elapsed;
    logic take_in;
    logic busy;
    logic free;
    logic lend;
    logic launch;
    logic [23:0] l_addr;
    logic [1:0] l_space;
    logic l_write;
    logic [23:0] l_wdata;
    logic [3:0] hit;
    logic [3:0] win;
    logic [1:0] area;

    // 0 timing, 1..4 attribute zero..three, 5 status, 7 unmapped
    function automatic logic [2:0] reg_index(input logic [AXI_AW-1:0] a);
        case (a)
            AXI_AW'(aas_pkg::OFS_BUS_TIMING): reg_index = 3'h0;
            AXI_AW'(aas_pkg::OFS_ATTR_ZERO): reg_index = 3'h1;
            AXI_AW'(aas_pkg::OFS_ATTR_ONE): reg_index = 3'h2;
            AXI_AW'(aas_pkg::OFS_ATTR_TWO): reg_index = 3'h3;
            AXI_AW'(aas_pkg::OFS_ATTR_THREE): reg_index = 3'h4;
            AXI_AW'(aas_pkg::OFS_STATUS): reg_index = 3'h5;
            default: reg_index = 3'h7;
        endcase
    endfunction

    function automatic logic [23:0] merge(input logic [23:0] old, input logic [23:0] d,
                                          input logic [2:0] strb);
        merge = old;
        for (int b = 0; b < 3; b++) begin
            if (strb[b]) begin
                merge[8*b +: 8] = d[8*b +: 8];
            end
        end
    endfunction

    // highest index wins; no hit falls back to area zero timing
    function automatic logic [5:0] pick(input logic [3:0] m);
        pick = 6'h00;
        for (int k = 0; k < 4; k++) begin
            if (m[k]) begin
                pick = {2'(k), 4'(1 << k)};
            end
        end
    endfunction

    assign busy = (s_r.state == aas_pkg::AAS_BUSY);
    assign take_in = acc_valid && s_r.acc_ready;
    assign free = (s_r.state == aas_pkg::AAS_IDLE) || (busy && fin);
    assign lend = free && ext_bus_req &&
        !s_r.bus_timing_control[aas_pkg::BUS_LOCK_HOLD_BIT];
    assign launch = free && (s_r.pend || take_in) && !lend;
    assign l_addr = s_r.pend ? s_r.pend_addr : acc_addr;
    assign l_space = s_r.pend ? s_r.pend_space : acc_space;
    assign l_write = s_r.pend ? s_r.pend_write : acc_write;
    assign l_wdata = s_r.pend ? s_r.pend_wdata : acc_wdata;
    assign {area, win} = pick(hit);

    genvar g;
    generate
        for (g = 0; g < aas_pkg::NUM_ATTR; g++) begin : g_match
            aas_attr_match u_match (
                .attr_reg(s_r.attr_select_reg[g]),
                .addr(l_addr),
                .space(l_space),
                .hit(hit[g])
            );
        end
    endgenerate

    aas_wait_gen u_wait (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(launch),
        .busy(busy),
        .wait_cnt(s_r.cur_wait),
        .ack(transfer_ack_in),
        .fin(fin),
        .elapsed(elapsed)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.acc_done = 1'h0;
        // register bus: address and data may arrive in either order
        if (s_r.awready && s_axi_awvalid) begin
            s_nxt.aw_got = 1'h1;
            s_nxt.wr_addr = s_axi_awaddr;
        end
        if (s_r.wready && s_axi_wvalid) begin
            s_nxt.w_got = 1'h1;
            s_nxt.wr_data = s_axi_wdata[23:0];
            s_nxt.wr_strb = s_axi_wstrb[2:0];
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'h0;
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'h0;
            s_nxt.w_got = 1'h0;
            s_nxt.bvalid = 1'h1;
            s_nxt.bresp = aas_pkg::RESP_OKAY;
            case (reg_index(s_r.wr_addr))
                3'h0: s_nxt.bus_timing_control = merge(s_r.bus_timing_control,
                                                       s_r.wr_data, s_r.wr_strb);
                3'h1, 3'h2, 3'h3, 3'h4: begin
                    s_nxt.attr_select_reg[2'(reg_index(s_r.wr_addr) - 3'h1)] =
                        merge(s_r.attr_select_reg[2'(reg_index(s_r.wr_addr) - 3'h1)],
                              s_r.wr_data, s_r.wr_strb);
                end
                3'h5: s_nxt.bresp = aas_pkg::RESP_OKAY;
                default: s_nxt.bresp = aas_pkg::RESP_SLVERR;
            endcase
        end
        s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'h0;
        end
        if (s_r.arready && s_axi_arvalid) begin
            s_nxt.rvalid = 1'h1;
            s_nxt.rresp = aas_pkg::RESP_OKAY;
            case (reg_index(s_axi_araddr))
                3'h0: s_nxt.rdata = s_r.bus_timing_control;
                3'h1, 3'h2, 3'h3, 3'h4: begin
                    s_nxt.rdata = s_r.attr_select_reg[2'(reg_index(s_axi_araddr) - 3'h1)];
                end
                3'h5: s_nxt.rdata = {13'h0000, s_r.cur_wait, s_r.sel, s_r.pend, s_r.grant};
                default: begin
                    s_nxt.rdata = 24'h00_0000;
                    s_nxt.rresp = aas_pkg::RESP_SLVERR;
                end
            endcase
        end
        s_nxt.arready = !s_nxt.rvalid;

        // external access sequencing
        if (fin) begin
            s_nxt.acc_done = 1'h1;
            if (!s_r.cur_write) begin
                s_nxt.acc_rdata = ext_data_in;
            end
        end
        if (launch && s_r.pend) begin
            s_nxt.pend = 1'h0;
        end
        if (take_in && !(launch && !s_r.pend)) begin
            s_nxt.pend = 1'h1;
            s_nxt.pend_addr = acc_addr;
            s_nxt.pend_space = acc_space;
            s_nxt.pend_write = acc_write;
            s_nxt.pend_wdata = acc_wdata;
        end
        case (s_r.state)
            aas_pkg::AAS_IDLE, aas_pkg::AAS_BUSY: begin
                if (launch) begin
                    // address, data and pins are loaded on the same edge
                    s_nxt.state = aas_pkg::AAS_BUSY;
                    s_nxt.ext_addr = l_addr;
                    s_nxt.sel = win;
                    s_nxt.cur_wait = s_r.bus_timing_control[
                        aas_pkg::AREA_WAIT_LSB + aas_pkg::WAIT_W * 32'(area) +: aas_pkg::WAIT_W
                    ];
                    s_nxt.cur_write = l_write;
                    s_nxt.rd_n = l_write;
                    s_nxt.wr_n = !l_write;
                    s_nxt.ext_dout = l_wdata;
                    s_nxt.ext_data_oe = l_write;
                end else if (free) begin
                    s_nxt.state = lend ? aas_pkg::AAS_LENT : aas_pkg::AAS_IDLE;
                    s_nxt.sel = 4'h0;
                    s_nxt.rd_n = 1'h1;
                    s_nxt.wr_n = 1'h1;
                    s_nxt.ext_data_oe = 1'h0;
                end
            end
            aas_pkg::AAS_LENT: begin
                // one access waits in the pending slot until the bus returns
                if (!ext_bus_req) begin
                    s_nxt.state = aas_pkg::AAS_IDLE;
                end
            end
            default: s_nxt.state = aas_pkg::AAS_IDLE;
        endcase
        s_nxt.acc_ready = !s_nxt.pend;
        s_nxt.grant = (s_nxt.state == aas_pkg::AAS_LENT);
        s_nxt.bus_oe = !s_nxt.grant;
        for (int k = 0; k < aas_pkg::NUM_ATTR; k++) begin
            s_nxt.pins[k] = s_nxt.attr_select_reg[k][aas_pkg::ATTR_POL_BIT] ?
                s_nxt.sel[k] : !s_nxt.sel[k];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.bus_timing_control <= aas_pkg::BUS_TIMING_RST;
            s_r.attr_select_reg <= {4{aas_pkg::ATTR_RST}};
            s_r.state <= aas_pkg::AAS_IDLE;
            s_r.rd_n <= 1'h1;
            s_r.wr_n <= 1'h1;
            s_r.bus_oe <= 1'h1;
            s_r.pins <= 4'hf;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rdata = {8'h00, s_r.rdata};
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign acc_ready = s_r.acc_ready;
    assign acc_done = s_r.acc_done;
    assign acc_rdata = s_r.acc_rdata;
    assign ext_addr = s_r.ext_addr;
    assign ext_data_out = s_r.ext_dout;
    assign ext_data_oe = s_r.ext_data_oe;
    assign ext_rd_n = s_r.rd_n;
    assign ext_wr_n = s_r.wr_n;
    assign ext_bus_oe = s_r.bus_oe;
    assign attr_select_pin = s_r.pins;
    assign ext_bus_grant = s_r.grant;

    property p_wait_count;
        @(posedge aclk) disable iff (!aresetn)
        fin |-> elapsed >= s_r.cur_wait;
    endproperty
    a_wait_count: assert property (p_wait_count) else $error("access ended early");

    property p_ack_holds;
        @(posedge aclk) disable iff (!aresetn)
        busy && !transfer_ack_in |=> !acc_done;
    endproperty
    a_ack_holds: assert property (p_ack_holds) else $error("done without ack");

    property p_wait_end;
        @(posedge aclk) disable iff (!aresetn)
        busy && transfer_ack_in && elapsed == s_r.cur_wait |=> acc_done;
    endproperty
    a_wait_end: assert property (p_wait_end) else $error("wait overran");

    property p_reset_clear;
        @(posedge aclk)
        $rose(aresetn) |-> s_r.attr_select_reg == '0 && attr_select_pin == 4'hf;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left attr set");

    property p_priority;
        @(posedge aclk) disable iff (!aresetn)
        launch && hit[3] |=> s_r.sel == 4'h8;
    endproperty
    a_priority: assert property (p_priority) else $error("priority lost");

    property p_no_match;
        @(posedge aclk) disable iff (!aresetn)
        launch && hit == 4'h0 |=> s_r.sel == 4'h0 ##1 1'b1;
    endproperty
    a_no_match: assert property (p_no_match) else $error("pin without match");

    property p_sel_needs_busy;
        @(posedge aclk) disable iff (!aresetn)
        s_r.sel != 4'h0 |-> busy && $onehot(s_r.sel);
    endproperty
    a_sel_needs_busy: assert property (p_sel_needs_busy) else $error("stray select");

    property p_negate;
        @(posedge aclk) disable iff (!aresetn)
        fin && !launch |=> s_r.sel == 4'h0 && ext_rd_n && ext_wr_n;
    endproperty
    a_negate: assert property (p_negate) else $error("pin not negated");

    property p_keep_pin;
        @(posedge aclk) disable iff (!aresetn)
        fin && launch && win == s_r.sel |=> $stable(s_r.sel);
    endproperty
    a_keep_pin: assert property (p_keep_pin) else $error("pin dropped between");

    property p_addr_timing;
        @(posedge aclk) disable iff (!aresetn)
        launch |=> ext_addr == $past(l_addr) && s_r.sel == $past(win);
    endproperty
    a_addr_timing: assert property (p_addr_timing) else $error("addr and pin skew");

    property p_lent_idle;
        @(posedge aclk) disable iff (!aresetn)
        ext_bus_grant |-> !busy && !ext_bus_oe && s_r.sel == 4'h0;
    endproperty
    a_lent_idle: assert property (p_lent_idle) else $error("bus lent while busy");

    property p_back_to_back;
        @(posedge aclk) disable iff (!aresetn)
        acc_done ##1 acc_done ##1 acc_done;
    endproperty
    c_back_to_back: cover property (p_back_to_back);

    property p_ack_stretch;
        @(posedge aclk) disable iff (!aresetn)
        (busy && !transfer_ack_in) [*3] ##2 acc_done;
    endproperty
    c_ack_stretch: cover property (p_ack_stretch);

    property p_lend;
        @(posedge aclk) disable iff (!aresetn)
        $rose(ext_bus_grant);
    endproperty
    c_lend: cover property (p_lend);
endmodule
`default_nettype wire

// ---- verif/aas_sram_model.sv ----
`default_nettype none
module aas_sram_model (
    input wire logic aclk,
    input wire logic [23:0] ext_addr,
    input wire logic [23:0] ext_data_out,
    input wire logic ext_rd_n,
    input wire logic ext_wr_n,
    input wire logic [4:0] ack_delay,
    output logic [23:0] ext_data_in,
    output logic transfer_ack_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] mem [256];
    logic [23:0] last_r = 24'h00_0000;
    logic [4:0] cnt_r = 5'h00;
    // ready held back until a strobe has been low ack_delay cycles
    assign transfer_ack_in = (cnt_r >= ack_delay);
    // released bus shows the inverse of the last value, so a stale read cannot match
    assign ext_data_in = !ext_rd_n ? mem[ext_addr[7:0]] : ~last_r;
    always @(posedge aclk) begin
        cnt_r <= (ext_rd_n && ext_wr_n) ? 5'h00 : cnt_r + 5'h01;
        if (!ext_rd_n) last_r <= mem[ext_addr[7:0]];
        if (!ext_wr_n) mem[ext_addr[7:0]] <= ext_data_out;
    end
endmodule
`default_nettype wire

// ---- verif/test_aas_chip_select.sv ----
`default_nettype none
module test_aas_chip_select;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0000_0000;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic acc_valid = 1'b0;
    logic acc_ready;
    logic [23:0] acc_addr = 24'h00_0000;
    logic [1:0] acc_space = 2'h0;
    logic acc_write = 1'b0;
    logic [23:0] acc_wdata = 24'h00_0000;
    logic acc_done;
    logic [23:0] acc_rdata;
    logic [23:0] ext_addr;
    logic [23:0] ext_data_out;
    logic [23:0] ext_data_in;
    logic data_oe;
    logic rd_n;
    logic wr_n;
    logic bus_oe;
    logic [3:0] pin;
    logic ack;
    logic bus_req = 1'b0;
    logic grant;
    logic [4:0] ack_delay = 5'h00;
    logic [7:0] ofs [4] = '{8'h04, 8'h08, 8'h0c, 8'h10};
    int fail_count = 0;
    int tests_run = 0;

    aas_chip_select i_aas_chip_select (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_addr(acc_addr),
        .acc_space(acc_space), .acc_write(acc_write), .acc_wdata(acc_wdata),
        .acc_done(acc_done), .acc_rdata(acc_rdata), .ext_addr(ext_addr),
        .ext_data_out(ext_data_out), .ext_data_oe(data_oe), .ext_data_in(ext_data_in),
        .ext_rd_n(rd_n), .ext_wr_n(wr_n), .ext_bus_oe(bus_oe), .attr_select_pin(pin),
        .transfer_ack_in(ack), .ext_bus_req(bus_req), .ext_bus_grant(grant));
    aas_sram_model i_aas_sram_model (.aclk(aclk), .ext_addr(ext_addr),
        .ext_data_out(ext_data_out), .ext_rd_n(rd_n), .ext_wr_n(wr_n),
        .ack_delay(ack_delay), .ext_data_in(ext_data_in), .transfer_ack_in(ack));

    always #50 aclk = ~aclk;

    task automatic conclude;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t value %h not %h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [23:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {8'h00, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask

    // one core access; elen counts edges from take to the done pulse
    task automatic core(input logic [23:0] a, input logic [1:0] sp, input logic w,
            input logic [23:0] d, input logic [3:0] epin, input int elen);
        int n;
        @(posedge aclk);
        acc_addr <= a;
        acc_space <= sp;
        acc_write <= w;
        acc_wdata <= d;
        acc_valid <= 1'b1;
        do @(posedge aclk); while (!acc_ready);
        acc_valid <= 1'b0;
        #1;
        chk(32'(ext_addr), 32'(a));
        chk(32'(pin), 32'(epin));
        chk(32'({data_oe, rd_n, wr_n}), 32'({w, w, !w}));
        for (n = 1; n < 40 && !acc_done; n++) begin
            @(posedge aclk);
            #1;
        end
        chk(n, elen);
        chk(32'(pin), 32'h0000_000f);
        if (!w) chk(32'(acc_rdata), 32'(d));
    endtask

    // two zero-wait accesses to one bank, issued back to back
    task automatic same_pin;
        int k;
        int d1;
        @(posedge aclk);
        acc_addr <= 24'h00_0001;
        acc_space <= aas_pkg::AAS_SPACE_P;
        acc_write <= 1'b1;
        acc_valid <= 1'b1;
        do @(posedge aclk); while (!acc_ready);
        acc_addr <= 24'h00_0002;
        do @(posedge aclk); while (!acc_ready);
        acc_valid <= 1'b0;
        d1 = 0;
        for (k = 1; k < 8; k++) begin
            #1;
            if (acc_done && d1 > 0) break;
            if (acc_done) d1 = k;
            chk(32'(pin), 32'h0000_000d);
            @(posedge aclk);
        end
        chk(k - d1, 32'h0000_0001);
    endtask

    task automatic lend;
        @(posedge aclk);
        bus_req <= 1'b1;
        repeat (3) @(posedge aclk);
        #1;
        chk(32'(grant), 32'h0000_0001);
        chk(32'(bus_oe), 32'h0000_0000);
        axi_rd(aas_pkg::OFS_STATUS, 32'h0000_0001, aas_pkg::RESP_OKAY);
        @(posedge aclk);
        bus_req <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
        chk(32'(grant), 32'h0000_0000);
        chk(32'(bus_oe), 32'h0000_0001);
        // lock hold bit set: the bus must stay with the device
        axi_wr(aas_pkg::OFS_BUS_TIMING, 24'h40_0000, aas_pkg::RESP_OKAY);
        bus_req <= 1'b1;
        repeat (3) @(posedge aclk);
        #1;
        chk(32'(grant), 32'h0000_0000);
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(aas_pkg::OFS_BUS_TIMING, 32'h000f_ffff, aas_pkg::RESP_OKAY);
        foreach (ofs[i]) begin
            axi_rd(ofs[i], 32'h0000_0000, aas_pkg::RESP_OKAY);
            axi_wr(ofs[i], 24'h5a_c300 | 24'(i), aas_pkg::RESP_OKAY);
            axi_rd(ofs[i], {8'h00, 24'h5a_c300 | 24'(i)}, aas_pkg::RESP_OKAY);
        end
        axi_rd(8'h18, 32'h0000_0000, aas_pkg::RESP_SLVERR);
        axi_wr(8'h18, 24'h00_0001, aas_pkg::RESP_SLVERR);
        // no space enabled anywhere, default area still at its full count
        core(24'h00_0040, aas_pkg::AAS_SPACE_P, 1'b1, 24'h12_3456, 4'hf, 33);
        axi_wr(aas_pkg::OFS_BUS_TIMING, 24'h00_8421, aas_pkg::RESP_OKAY);
        axi_wr(aas_pkg::OFS_ATTR_THREE, 24'h01_0908, aas_pkg::RESP_OKAY);
        axi_wr(aas_pkg::OFS_ATTR_TWO, 24'h00_8908, aas_pkg::RESP_OKAY);
        axi_wr(aas_pkg::OFS_ATTR_ONE, 24'h00_0908, aas_pkg::RESP_OKAY);
        core(24'h01_0000, aas_pkg::AAS_SPACE_P, 1'b1, 24'h00_0000, 4'h7, 3);
        core(24'h01_0005, aas_pkg::AAS_SPACE_P, 1'b1, 24'ha5_c3f0, 4'h7, 3);
        core(24'h01_0005, aas_pkg::AAS_SPACE_P, 1'b0, 24'ha5_c3f0, 4'h7, 3);
        core(24'h00_8006, aas_pkg::AAS_SPACE_P, 1'b1, 24'h3c_0ff1, 4'hb, 3);
        core(24'h00_0007, aas_pkg::AAS_SPACE_P, 1'b1, 24'h96_e1d2, 4'hd, 3);
        core(24'h00_0008, aas_pkg::AAS_SPACE_X, 1'b1, 24'h00_0001, 4'hf, 3);
        core(24'h01_8009, aas_pkg::AAS_SPACE_P, 1'b1, 24'h00_0002, 4'hf, 3);
        ack_delay <= 5'h03;
        core(24'h00_0007, aas_pkg::AAS_SPACE_P, 1'b0, 24'h96_e1d2, 4'hd, 5);
        ack_delay <= 5'h00;
        axi_wr(aas_pkg::OFS_ATTR_ZERO, 24'h00_0008, aas_pkg::RESP_OKAY);
        core(24'h01_8009, aas_pkg::AAS_SPACE_P, 1'b1, 24'h00_0003, 4'he, 3);
        core(24'h01_0005, aas_pkg::AAS_SPACE_P, 1'b1, 24'h00_0004, 4'h7, 3);
        axi_wr(aas_pkg::OFS_BUS_TIMING, 24'h0f_8421, aas_pkg::RESP_OKAY);
        core(24'h01_0005, aas_pkg::AAS_SPACE_P, 1'b1, 24'h00_0005, 4'h7, 33);
        axi_wr(aas_pkg::OFS_BUS_TIMING, 24'h00_0000, aas_pkg::RESP_OKAY);
        same_pin();
        // two-to-one split: bit 15 picks bank three or two, other space on pin one
        axi_wr(aas_pkg::OFS_ATTR_THREE, 24'h00_8908, aas_pkg::RESP_OKAY);
        axi_wr(aas_pkg::OFS_ATTR_TWO, 24'h00_0908, aas_pkg::RESP_OKAY);
        axi_wr(aas_pkg::OFS_ATTR_ONE, 24'h00_0010, aas_pkg::RESP_OKAY);
        core(24'h00_8003, aas_pkg::AAS_SPACE_P, 1'b1, 24'h00_0006, 4'h7, 2);
        core(24'h00_0004, aas_pkg::AAS_SPACE_P, 1'b1, 24'h00_0007, 4'hb, 2);
        core(24'h00_0005, aas_pkg::AAS_SPACE_X, 1'b1, 24'h00_0008, 4'hd, 2);
        lend();
        conclude();
    end

    // whole run is a few hundred cycles; this allows ample margin
    initial begin
        #2_000_000;
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
